// [common/tcdio_consts.svh]
// register offsets, field positions and reset values
`ifndef TCDIO_CONSTS_SVH
`define TCDIO_CONSTS_SVH
`define TCDIO_OFF_CTRL     12'h000
`define TCDIO_OFF_STATUS   12'h004
`define TCDIO_OFF_COUNT    12'h008
`define TCDIO_OFF_LIMIT    12'h00c
`define TCDIO_OFF_CAPTURE  12'h010
`define TCDIO_OFF_DIN0     12'h014
`define TCDIO_OFF_DIN1     12'h018
`define TCDIO_OFF_DOUT0    12'h01c
`define TCDIO_OFF_DOUT1    12'h020
`define TCDIO_OFF_DOUTS    12'h024
`define TCDIO_OFF_IRQ_EN   12'h028
`define TCDIO_OFF_IRQ_CLR  12'h02c
`define TCDIO_OFF_TASK     12'h030
`define TCDIO_TE_LSB       0
`define TCDIO_EN_BIT       3
`define TCDIO_CS_BIT       4
`define TCDIO_PS_LSB       5
`define TCDIO_MODE_LSB     7
`define TCDIO_CTRL_W       9
`define TCDIO_ST_EVT       0
`define TCDIO_ST_WRAP      1
`define TCDIO_LIMIT_RST    16'hffff
`endif

// [common/tcdio_pkg.sv]
// types shared by the timer and digital io block
package tcdio_pkg;
	typedef enum logic [1:0] {
		TCDIO_FREE,
		TCDIO_CAP_RISE,
		TCDIO_CAP_FALL,
		TCDIO_MODE_RSVD
	} tcdio_mode_t;

	typedef struct packed {
		tcdio_mode_t mode;
		logic [1:0]  prescale;
		logic        extClk;
		logic        enable;
		logic [2:0]  taskSel;
	} tcdio_ctrl_t;

	typedef struct packed {
		logic wrap;
		logic evt;
	} tcdio_flags_t;
endpackage : tcdio_pkg

// [core/tcdio_timer.sv]
// 16-bit timer with capture, status flags and two digital ins and outs
`timescale 1ns/10ps
`include "tcdio_consts.svh"

// What this block does
// - event flag sets on timer event; clears on task done when the task selection is nonzero, else on status read
// - wrap flag sets on every wrap, clears on status read
// - live count readable; writes load the counter at once
// - writable wrap limit; counter wraps at it, takes effect at once
// - capture modes latch the count into a read-write capture cache
// - each digital input reads as one bit, high reads 1
// - each digital output driven by its own writable bit
// - combined two-bit output register aliases both output bits
// - mode 0 free run, 1 capture rising, 2 capture falling
// - internal clock prescaled 1,4,16,64 or external clock input
// - counting only while the enable bit is set
// - task selection: 0 none, 1 to 4 event tasks zero to three
module tcdio_timer
	import tcdio_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        clkEn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        captureInput,
	input  wire logic        externalClockInput,
	output logic      [1:0]  digitalOut,
	output logic      [3:0]  taskRequest,
	input  wire logic        taskDone,
	output logic             irq
);
	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	tcdio_ctrl_t        ctrl_q;
	tcdio_flags_t       flags_q;
	tcdio_flags_t       irqEn_q;
	logic [CNT_W-1:0]   count_q;
	logic [CNT_W-1:0]   limit_q;
	logic [CNT_W-1:0]   capture_q;
	logic [1:0]         dout_q;
	logic [5:0]         pre_q;
	logic               cap_q;
	logic               ext_q;
	logic [3:0]         task_q;
	logic [31:0]        rdata_q;

	wire logic acc = psel && penable && clkEn;
	wire logic wr  = acc && pwrite;
	wire logic rd  = acc && !pwrite;
	wire logic hitCtrl  = paddr == `TCDIO_OFF_CTRL;
	wire logic hitStat  = paddr == `TCDIO_OFF_STATUS;
	wire logic hitCount = paddr == `TCDIO_OFF_COUNT;
	wire logic hitLimit = paddr == `TCDIO_OFF_LIMIT;
	wire logic hitCap   = paddr == `TCDIO_OFF_CAPTURE;
	wire logic hitDin0  = paddr == `TCDIO_OFF_DIN0;
	wire logic hitDin1  = paddr == `TCDIO_OFF_DIN1;
	wire logic hitDout0 = paddr == `TCDIO_OFF_DOUT0;
	wire logic hitDout1 = paddr == `TCDIO_OFF_DOUT1;
	wire logic hitDouts = paddr == `TCDIO_OFF_DOUTS;
	wire logic hitIrqEn = paddr == `TCDIO_OFF_IRQ_EN;
	wire logic hitIrqCl = paddr == `TCDIO_OFF_IRQ_CLR;
	wire logic hitTask  = paddr == `TCDIO_OFF_TASK;
	wire logic hitAny   = hitCtrl | hitStat | hitCount | hitLimit | hitCap
		| hitDin0 | hitDin1 | hitDout0 | hitDout1 | hitDouts | hitIrqEn
		| hitIrqCl | hitTask;

	// no wait states: the slave answers in the first access cycle
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hitAny;

	// ------------------------------------------------------------
	// tick generation
	// ------------------------------------------------------------
	function automatic logic preTick(input logic [1:0] sel,
		input logic [5:0] cnt);
		unique case (sel)
			2'h0: preTick = 1'b1;
			2'h1: preTick = cnt[1:0] == 2'h3;
			2'h2: preTick = cnt[3:0] == 4'hf;
			2'h3: preTick = cnt == 6'h3f;
		endcase
	endfunction : preTick

	// external clock counted on its rising edge, input taken as synchronous
	wire logic extRise = externalClockInput && !ext_q;
	wire logic tick    = ctrl_q.enable && (ctrl_q.extClk ? extRise
		: preTick(ctrl_q.prescale, pre_q));
	wire logic atLimit = count_q >= limit_q;
	wire logic wrapEvt = tick && atLimit;
	wire logic capRise = captureInput && !cap_q;
	wire logic capFall = !captureInput && cap_q;
	wire logic capEvt  = ctrl_q.enable &&
		((ctrl_q.mode == TCDIO_CAP_RISE && capRise) ||
		 (ctrl_q.mode == TCDIO_CAP_FALL && capFall));
	wire logic timerEvt = capEvt ||
		(ctrl_q.mode == TCDIO_FREE && wrapEvt);
	wire logic [CNT_W-1:0] countInc = count_q + CNT_W'(1);

	// ------------------------------------------------------------
	// status flags: a set in the same cycle as a clear wins
	// ------------------------------------------------------------
	wire logic statRead = rd && hitStat;
	wire logic evtAuto  = ctrl_q.taskSel != 3'h0;
	wire logic evtClr   = evtAuto ? taskDone : statRead;
	wire logic wrapClr  = statRead || (wr && hitIrqCl &&
		pwdata[`TCDIO_ST_WRAP]);
	wire logic evtClrW  = evtClr || (wr && hitIrqCl &&
		pwdata[`TCDIO_ST_EVT]);
	tcdio_flags_t flags_d;
	assign flags_d.evt  = timerEvt || (flags_q.evt && !evtClrW);
	assign flags_d.wrap = wrapEvt || (flags_q.wrap && !wrapClr);

	// task request: one-hot, held until the event flag clears
	function automatic logic [3:0] taskDecode(input logic [2:0] sel);
		unique case (sel)
			3'h1: taskDecode = 4'h1;
			3'h2: taskDecode = 4'h2;
			3'h3: taskDecode = 4'h4;
			3'h4: taskDecode = 4'h8;
			default: taskDecode = 4'h0;
		endcase
	endfunction : taskDecode

	wire logic [3:0] task_d = flags_d.evt ?
		(flags_q.evt ? task_q : taskDecode(ctrl_q.taskSel)) : 4'h0;

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0;
		if (hitCtrl)  rmux = {23'h0, ctrl_q};
		if (hitStat)  rmux = {30'h0, flags_q};
		if (hitCount) rmux = 32'(count_q);
		if (hitLimit) rmux = 32'(limit_q);
		if (hitCap)   rmux = 32'(capture_q);
		if (hitDin0)  rmux = {31'h0, captureInput};
		if (hitDin1)  rmux = {31'h0, externalClockInput};
		if (hitDout0) rmux = {31'h0, dout_q[0]};
		if (hitDout1) rmux = {31'h0, dout_q[1]};
		if (hitDouts) rmux = {30'h0, dout_q};
		if (hitIrqEn) rmux = {30'h0, irqEn_q};
		if (hitTask)  rmux = {28'h0, task_q};
	end

	// ------------------------------------------------------------
	// next values
	// ------------------------------------------------------------
	// a software load beats the tick in the same cycle
	logic [CNT_W-1:0] count_d;
	assign count_d = (wr && hitCount) ? pwdata[CNT_W-1:0]
		: wrapEvt ? '0
		: tick ? countInc : count_q;
	logic [CNT_W-1:0] limit_d;
	assign limit_d = (wr && hitLimit) ? pwdata[CNT_W-1:0] : limit_q;
	// a capture edge beats a software write in the same cycle
	logic [CNT_W-1:0] capture_d;
	assign capture_d = capEvt ? count_q
		: (wr && hitCap) ? pwdata[CNT_W-1:0] : capture_q;
	tcdio_ctrl_t ctrl_d;
	assign ctrl_d = (wr && hitCtrl)
		? tcdio_ctrl_t'(pwdata[`TCDIO_CTRL_W-1:0]) : ctrl_q;
	tcdio_flags_t irqEn_d;
	assign irqEn_d = (wr && hitIrqEn) ? tcdio_flags_t'(pwdata[1:0]) : irqEn_q;
	// the single-bit views and the combined view share one state
	logic [1:0] dout_d;
	assign dout_d[0] = (wr && hitDouts) ? pwdata[0]
		: (wr && hitDout0) ? pwdata[0] : dout_q[0];
	assign dout_d[1] = (wr && hitDouts) ? pwdata[1]
		: (wr && hitDout1) ? pwdata[0] : dout_q[1];
	// prescaler restarts whenever the timer is disabled
	logic [5:0] pre_d;
	assign pre_d = ctrl_q.enable ? pre_q + 6'h1 : 6'h0;
	// read data holds the last value once the access ends
	logic [31:0] rdata_d;
	assign rdata_d = rd ? rmux : rdata_q;

	// ------------------------------------------------------------
	// state: one short block per register, frozen while clkEn is low unless rst_n is low
	// ------------------------------------------------------------
	// mode 3 is left as a free run that raises no event
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctrl_q <= '0;
		end else if (clkEn) begin
			ctrl_q <= ctrl_d;
		end
	end

	// flags and task request update together so they never disagree
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			flags_q <= '0;
		end else if (clkEn) begin
			flags_q <= flags_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			irqEn_q <= '0;
		end else if (clkEn) begin
			irqEn_q <= irqEn_d;
		end
	end

	// a counter above a lowered limit wraps on the next tick
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			count_q <= '0;
		end else if (clkEn) begin
			count_q <= count_d;
		end
	end

	// the limit resets to the full counter range
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			limit_q <= `TCDIO_LIMIT_RST;
		end else if (clkEn) begin
			limit_q <= limit_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			capture_q <= '0;
		end else if (clkEn) begin
			capture_q <= capture_d;
		end
	end

	// outputs come up low
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dout_q <= 2'h0;
		end else if (clkEn) begin
			dout_q <= dout_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pre_q <= 6'h0;
		end else if (clkEn) begin
			pre_q <= pre_d;
		end
	end

	// previous samples for edge detection, reset to the idle low level
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cap_q <= 1'b0;
		end else if (clkEn) begin
			cap_q <= captureInput;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ext_q <= 1'b0;
		end else if (clkEn) begin
			ext_q <= externalClockInput;
		end
	end

	// task request tracks the event flag on the same edge
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			task_q <= 4'h0;
		end else if (clkEn) begin
			task_q <= task_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdata_q <= 32'h0;
		end else if (clkEn) begin
			rdata_q <= rdata_d;
		end
	end

	// read data is registered but the mux is live in the access cycle
	assign prdata      = rd ? rmux : rdata_q;
	assign digitalOut  = dout_q;
	assign taskRequest = task_q;
	assign irq         = |(flags_q & irqEn_q);
endmodule : tcdio_timer

// [tb/tcdio_timer_props.sv]
// concurrent checks on the ports of the timer and digital io block
`timescale 1ns/10ps
module tcdio_timer_props (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        clkEn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [1:0]  digitalOut,
	input wire logic [3:0]  taskRequest,
	input wire logic        irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire inMap = paddr <= 12'h030 && paddr[1:0] == 2'h0;
	sequence wrS(logic [11:0] a);
		psel && penable && pwrite && clkEn && paddr == a;
	endsequence
	a_ready_high:
		assert property (psel && penable |-> pready) else $error("no ready");
	a_unmapped_err:
		assert property (psel && penable |-> pslverr == !inMap)
			else $error("slverr wrong");
	a_unmapped_zero:
		assert property (psel && penable && !pwrite && !inMap |-> prdata == 32'h0)
			else $error("unmapped read not zero");
	a_dout_zero:
		assert property (wrS(12'h01c) |=> digitalOut[0] == $past(pwdata[0]))
			else $error("output 0 write lost");
	a_dout_one:
		assert property (wrS(12'h020) |=> digitalOut[1] == $past(pwdata[0]))
			else $error("output 1 write lost");
	a_dout_both:
		assert property (wrS(12'h024) |=> digitalOut == $past(pwdata[1:0]))
			else $error("combined write lost");
	a_dout_hold:
		assert property (!(psel && penable && pwrite) |=> $stable(digitalOut))
			else $error("output moved without write");
	a_task_onehot:
		assert property ($onehot0(taskRequest)) else $error("task not one-hot");
	a_reset_clear:
		assert property ($rose(rst_n) |-> digitalOut == 2'h0 && !irq
			&& taskRequest == 4'h0) else $error("outputs not reset");
endmodule : tcdio_timer_props
bind tcdio_timer tcdio_timer_props u_props (.clk_sys(clk_sys), .rst_n(rst_n),
	.clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .digitalOut(digitalOut), .taskRequest(taskRequest),
	.irq(irq));

// [tb/test_tcdio_timer.sv]
// self-checking bench for the timer and digital io block
`timescale 1ns/10ps
`include "tcdio_consts.svh"
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin \
	badCount++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module test_tcdio_timer;
	localparam logic [11:0] CT = `TCDIO_OFF_CTRL, ST = `TCDIO_OFF_STATUS,
		CN = `TCDIO_OFF_COUNT, LM = `TCDIO_OFF_LIMIT, CP = `TCDIO_OFF_CAPTURE;
	localparam logic [11:0] O0 = `TCDIO_OFF_DOUT0, O1 = `TCDIO_OFF_DOUT1,
		OS = `TCDIO_OFF_DOUTS, IE = `TCDIO_OFF_IRQ_EN, IC = `TCDIO_OFF_IRQ_CLR;
	logic clk_sys, rst_n, clkEn, psel, penable, pwrite, pready, pslverr, irq;
	logic captureInput, externalClockInput, taskDone, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  digitalOut;
	logic [3:0]  taskRequest;
	int          badCount, checkCount;
	tcdio_timer u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.captureInput(captureInput), .externalClockInput(externalClockInput),
		.digitalOut(digitalOut), .taskRequest(taskRequest),
		.taskDone(taskDone), .irq(irq));
	// ----------------------------------------
	// bus and helper tasks
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
		logic rdy;
		@(posedge clk_sys);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		// answer is read settled in the access cycle, taken at the next edge
		do begin
			@(negedge clk_sys);
			rdy = pready;
			rd = prdata;
			err = pslverr;
			@(posedge clk_sys);
		end while (rdy !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask : xf
	task automatic rc(input logic [11:0] a, input logic [31:0] e, string n);
		xf(1'b0, a, 32'h0);
		`CHK(n, e, rd)
	endtask : rc
	task automatic closeOut;
		if (badCount == 0 && checkCount > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : closeOut
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic tRegs;
		rc(CN, 32'h0, "cnt rst");
		`CHK("slverr ok", 1'b0, err)
		rc(LM, 32'hffff, "lim rst");
		rc(ST, 32'h0, "st rst");
		xf(1'b1, CN, 32'hab);
		rc(CN, 32'hab, "cnt");
		xf(1'b1, LM, 32'h1234);
		rc(LM, 32'h1234, "lim");
		xf(1'b1, CP, 32'h5a5a);
		rc(CP, 32'h5a5a, "cap");
		rc(12'h040, 32'h0, "unmapped");
		`CHK("slverr", 1'b1, err)
	endtask : tRegs
	task automatic tDio;
		{captureInput, externalClockInput} <= 2'b10;
		cyc(4);
		rc(`TCDIO_OFF_DIN0, 32'h1, "din0 hi");
		rc(`TCDIO_OFF_DIN1, 32'h0, "din1 lo");
		{captureInput, externalClockInput} <= 2'b01;
		cyc(4);
		rc(`TCDIO_OFF_DIN0, 32'h0, "din0 lo");
		rc(`TCDIO_OFF_DIN1, 32'h1, "din1 hi");
		externalClockInput <= 1'b0;
		xf(1'b1, O0, 32'h1);
		xf(1'b1, O1, 32'h1);
		cyc(1);
		`CHK("dout", 2'h3, digitalOut)
		xf(1'b1, O0, 32'h0);
		rc(OS, 32'h2, "douts");
		xf(1'b1, OS, 32'h1);
		rc(O1, 32'h0, "dout1");
		`CHK("dout2", 2'h1, digitalOut)
	endtask : tDio
	task automatic tExt;
		// a full-range limit keeps the wrap rate low
		xf(1'b1, LM, 32'hffff);
		xf(1'b1, CN, 32'h0);
		xf(1'b1, CT, 32'h018);
		for (int i = 0; i < 6; i++) begin
			if (i == 5) xf(1'b1, CT, 32'h010);
			externalClockInput <= 1'b1;
			cyc(4);
			externalClockInput <= 1'b0;
			cyc(4);
		end
		rc(CN, 32'h5, "ext cnt");
	endtask : tExt
	task automatic tCount;
		xf(1'b1, LM, 32'h3);
		for (int s = 1; s <= 4; s++) begin
			xf(1'b1, CN, 32'h0);
			xf(1'b1, IE, 32'h3);
			// prescale walks 1,4,16,64 so 400 cycles still see a wrap
			xf(1'b1, CT, 32'((s - 1) << 5 | 8 | s));
			cyc(400);
			xf(1'b1, CT, 32'(s));
			`CHK("task", 4'(1 << (s - 1)), taskRequest)
			`CHK("irq", 1'b1, irq)
			xf(1'b0, CN, 32'h0);
			`CHK("cnt max", 1'b1, rd <= 32'h3)
			rc(ST, 32'h3, "st both");
			rc(ST, 32'h1, "st evt");
			xf(1'b1, IE, 32'h0);
			cyc(1);
			`CHK("irq mask", 1'b0, irq)
			taskDone <= 1'b1;
			cyc(1);
			taskDone <= 1'b0;
			rc(ST, 32'h0, "st done");
			`CHK("task off", 4'h0, taskRequest)
		end
	endtask : tCount
	task automatic tCap;
		xf(1'b1, CT, 32'h098);
		xf(1'b1, CN, 32'h1234);
		captureInput <= 1'b1;
		cyc(4);
		rc(CP, 32'h1234, "cap rise");
		rc(ST, 32'h1, "st cap");
		rc(ST, 32'h0, "st rdclr");
		xf(1'b1, CT, 32'h118);
		xf(1'b1, CN, 32'h42);
		captureInput <= 1'b0;
		cyc(4);
		rc(CP, 32'h42, "cap fall");
		xf(1'b1, IE, 32'h1);
		cyc(1);
		`CHK("irq cap", 1'b1, irq)
		xf(1'b1, IC, 32'h1);
		cyc(1);
		`CHK("irq clr", 1'b0, irq)
	endtask : tCap
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		{rst_n, psel, penable, pwrite, captureInput, taskDone} = 6'h0;
		{externalClockInput, paddr, pwdata, clkEn} = 46'h1;
		cyc(20);
		rst_n <= 1'b1;
		tRegs();
		tDio();
		tExt();
		tCount();
		tCap();
		closeOut();
	end
	initial begin
		cyc(20000);
		badCount++;
		closeOut();
	end
endmodule : test_tcdio_timer
